// *** dv/sram_ctrl_model.sv ***
// controller side of the pin bus: address, control and write data
// assumes the bench issues one cycle per call of drive
`timescale 1ns/1ps

module sram_ctrl_model (
    input  wire logic            sys_clk,
    output zbl_sram_pkg::ctrl_s  ctrlIn,
    output zbl_sram_pkg::word_s  busIn
);
    // idle pins: every edge ignored until the first cycle
    initial begin
        ctrlIn = 26'h3FFFFFF;
        busIn  = 18'h00000;
    end

    // control of this cycle with data of the previous one, so strobes
    // always lead their data by one cycle
    task automatic drive(input zbl_sram_pkg::ctrl_s c,
            input zbl_sram_pkg::word_s d, input logic hasD);
        @(posedge sys_clk);
        ctrlIn <= c;
        // released data lines flip, so a stale word never matches
        busIn  <= hasD ? d : zbl_sram_pkg::word_s'(~busIn);
    endtask
endmodule

// *** dv/zbl_sram_port_asserts.sv ***
// pin-level checker of the sram port, bound onto every port instance
// assumes the unclocked pins take effect within three edges of a change
`timescale 1ns/1ps

module zbl_sram_port_asserts (
    input wire logic                sys_clk,
    input wire logic                rst_b,
    input wire zbl_sram_pkg::ctrl_s ctrlIn,
    input wire logic                outputEnable_b,
    input wire logic                sleepRequest,
    input wire zbl_sram_pkg::word_s busOut_reg,
    input wire logic                busOe_reg,
    input wire logic                lowPower_reg
);
    logic [2:0] slpHist; // past samples of sleep
    logic [1:0] oeHist;  // past samples of oe
    // cycle kinds decoded from the clocked pins and from the oe and sleep history
    wire en     = !ctrlIn.clockEnable_b;
    wire sel    = !ctrlIn.selectLowFirst_b && !ctrlIn.selectLowSecond_b
                  && ctrlIn.selectHigh;
    wire ld     = en && !ctrlIn.advanceOrLoad;
    wire awake  = !sleepRequest && slpHist == 3'h0;
    wire asleep = sleepRequest && slpHist[1:0] == 2'h3;
    wire oeOn   = !outputEnable_b && oeHist == 2'h0;
    wire oeOff  = outputEnable_b && oeHist == 2'h3;

    // pin history; mixed reset value keeps every window shut after reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            slpHist <= 3'h5;
            oeHist  <= 2'h1;
        end else begin
            slpHist <= {slpHist[1:0], sleepRequest};
            oeHist  <= {oeHist[0], outputEnable_b};
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    write_off_a: assert property (
        ld && sel && !ctrlIn.readNotWrite && awake |=> !busOe_reg)
        else $error("bus driven after a write load");
    read_on_a: assert property (
        ld && sel && ctrlIn.readNotWrite && awake && oeOn
        |=> busOe_reg && !lowPower_reg)
        else $error("read load did not drive the bus");
    desel_down_a: assert property (
        ld && !sel && awake |=> !busOe_reg && lowPower_reg)
        else $error("deselect left the port active");
    nop_float_a: assert property (
        ld && !sel && awake ##1 en && ctrlIn.advanceOrLoad && awake
        |=> !busOe_reg)
        else $error("advance after deselect drove the bus");
    dummy_read_a: assert property (
        ld && sel && ctrlIn.readNotWrite && awake && oeOff |=> !busOe_reg)
        else $error("dummy read drove the bus");
    hold_edge_a: assert property (
        ctrlIn.clockEnable_b && awake |=> $stable(busOut_reg))
        else $error("read data moved on an ignored edge");
    sleep_quiet_a: assert property (
        asleep |=> (lowPower_reg && !busOe_reg) [*2])
        else $error("port active while asleep");
    oe_float_a: assert property (
        oeOff |=> !busOe_reg)
        else $error("bus driven with output enable high");
endmodule

bind zbl_sram_port zbl_sram_port_asserts chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .ctrlIn(ctrlIn),
    .outputEnable_b(outputEnable_b), .sleepRequest(sleepRequest),
    .busOut_reg(busOut_reg), .busOe_reg(busOe_reg),
    .lowPower_reg(lowPower_reg));

// *** dv/zero_latency_burst_sram_port_tb.sv ***
// self-checking bench of the sram port with a controller model
// assumes pin changes of oe, sleep and order settle within 3 edges
`timescale 1ns/1ps

module zero_latency_burst_sram_port_tb;
    logic                sys_clk;        // 200 MHz clock
    logic                rst_b;          // async reset, active low
    logic                outputEnable_b; // read drive enable
    logic                sleepRequest;   // standby request
    logic                burstOrderSel;  // 1 or open: interleaved
    logic                busOe_reg;      // port drives the pins
    logic                lowPower_reg;   // port powered down
    zbl_sram_pkg::ctrl_s ctrlIn;         // clocked control pins
    zbl_sram_pkg::word_s busIn;          // write data
    zbl_sram_pkg::word_s busOut_reg;     // read data
    zbl_sram_pkg::word_s pins;           // resolved data wire
    zbl_sram_pkg::word_s exp [16];       // expected words 0 to 15
    int                  num_errors = 0; // mismatches
    int                  checked = 0;    // comparisons

    assign pins = busOe_reg ? busOut_reg : {18{1'bz}};

    // clock, 5 ns period
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    zbl_sram_port DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .ctrlIn(ctrlIn),
        .outputEnable_b(outputEnable_b), .sleepRequest(sleepRequest),
        .burstOrderSel(burstOrderSel), .busIn(busIn),
        .busOut_reg(busOut_reg), .busOe_reg(busOe_reg),
        .lowPower_reg(lowPower_reg));
    sram_ctrl_model ctl (.sys_clk(sys_clk), .ctrlIn(ctrlIn), .busIn(busIn));

    // word result; case equality so floating or unknown passes only where it is expected
    task automatic cmpW(input zbl_sram_pkg::word_s g, e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: word %h want %h", $time, g, e);
        end
    endtask

    // flag result
    task automatic cmpB(input logic g, e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: flag %b want %b", $time, g, e);
        end
    endtask

    // selected enabled cycle; stb bit 0 is lane a, active low
    function automatic zbl_sram_pkg::ctrl_s op(input logic adv, rnw,
            input logic [1:0] stb, input logic [3:0] a);
        op = {3'h1, adv, rnw, stb[0], stb[1], 1'b0, 14'h0000, a};
    endfunction

    // word of burst step n; two-bit step wraps back to the start
    function automatic logic [3:0] ba(input logic [3:0] a, input int n,
            input logic il);
        ba = il ? a ^ {2'h0, 2'(n)} : {a[3:2], a[1:0] + 2'(n)};
    endfunction

    // one write beat on the expected array; both strobes high: no change
    task automatic merge(input logic [3:0] i, input logic [1:0] s,
            input zbl_sram_pkg::word_s d);
        if (!s[0]) exp[i][8:0] = d[8:0];
        if (!s[1]) exp[i][17:9] = d[17:9];
    endtask

    task automatic t_powerup();
        repeat (8) @(posedge sys_clk);
        cmpB(busOe_reg, 1'b0);
        cmpB(lowPower_reg, 1'b1);
        rst_b <= 1'b1;
        $display("test powerup done");
    endtask

    // seven-beat write burst with lane mixes, read back with no gap
    task automatic t_burst(input logic il, input logic [3:0] a);
        zbl_sram_pkg::word_s d [7];
        zbl_sram_pkg::ctrl_s c;
        logic [1:0] stb [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h3};
        burstOrderSel <= il ? 1'bz : 1'b0;
        repeat (3) @(posedge sys_clk);
        for (int n = 0; n < 7; n++) begin
            d[n] = 18'h2D0C3 + 18'h01357 * 18'(n) + 18'(a);
            // advance ignores address and direction
            c = n ? op(1'b1, 1'b1, stb[n], ~a) : op(1'b0, 1'b0, 2'h0, a);
            ctl.drive(c, d[n ? n - 1 : 0], n > 0);
            if (n) begin
                #1;
                cmpB(busOe_reg, 1'b0);
                merge(ba(a, n - 1, il), stb[n - 1], d[n - 1]);
            end
        end
        for (int n = 0; n < 6; n++) begin
            // read burst keeps direction despite low write pins
            c = n ? op(1'b1, 1'b0, 2'h0, ~a) : op(1'b0, 1'b1, 2'h3, a);
            ctl.drive(c, d[6], n == 0);
            if (n == 0) merge(ba(a, 6, il), stb[6], d[6]);
            else begin
                #1;
                cmpW(pins, exp[ba(a, n - 1, il)]);
            end
        end
        c = op(1'b0, 1'b1, 2'h3, a);
        c.selectHigh = 1'b0;
        ctl.drive(c, busIn, 1'b0);
        ctl.drive(op(1'b1, 1'b1, 2'h3, a), busIn, 1'b0);
        #1;
        cmpB(lowPower_reg, 1'b1);
        ctl.drive(c, busIn, 1'b0);
        #1;
        cmpW(pins, {18{1'bz}});
        $display("test burst done");
    endtask

    // ignored edges, dummy read, then each select pin wrong in turn
    task automatic t_modes(input logic [3:0] a);
        zbl_sram_pkg::ctrl_s c;
        ctl.drive(op(1'b0, 1'b1, 2'h3, a), busIn, 1'b0);
        c = op(1'b0, 1'b1, 2'h3, a ^ 4'h1);
        c.clockEnable_b = 1'b1;
        repeat (2) ctl.drive(c, busIn, 1'b0);
        #1;
        cmpW(pins, exp[a]);
        outputEnable_b <= 1'b1;
        repeat (4) ctl.drive(op(1'b0, 1'b1, 2'h3, a), busIn, 1'b0);
        #1;
        cmpW(pins, {18{1'bz}});
        outputEnable_b <= 1'b0;
        repeat (2) ctl.drive(op(1'b0, 1'b1, 2'h3, a), busIn, 1'b0);
        for (int k = 0; k < 7; k++) begin
            c = op(1'b0, 1'b1, 2'h3, a);
            if (k % 2) c[25 - k / 2] = ~c[25 - k / 2];
            ctl.drive(c, busIn, 1'b0);
            // let the port sample this cycle before judging its flag
            @(posedge sys_clk);
            #1;
            cmpB(busOe_reg, k % 2 == 0);
        end
        $display("test modes done");
    endtask

    // standby ignores a full write; open sleep pin wakes the port
    task automatic t_sleep(input logic [3:0] a);
        zbl_sram_pkg::ctrl_s c;
        c = op(1'b0, 1'b1, 2'h3, a);
        c.selectHigh = 1'b0;
        ctl.drive(c, busIn, 1'b0); // last write long complete
        sleepRequest <= 1'b1;
        repeat (3) ctl.drive(c, busIn, 1'b0);
        ctl.drive(op(1'b0, 1'b0, 2'h0, a), busIn, 1'b0);
        ctl.drive(c, ~exp[a], 1'b1);
        #1;
        cmpB(lowPower_reg, 1'b1);
        sleepRequest <= 1'bz;
        repeat (3) ctl.drive(c, busIn, 1'b0);
        ctl.drive(op(1'b0, 1'b1, 2'h3, a), busIn, 1'b0);
        ctl.drive(c, busIn, 1'b0);
        #1;
        cmpW(pins, exp[a]);
        sleepRequest <= 1'b0;
        $display("test sleep done");
    endtask

    // counts, verdict, end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard; the tests need well under 400 cycles
    initial begin
        repeat (2000) @(posedge sys_clk);
        num_errors++;
        $display("wrong value at %0t: run timed out", $time);
        complete_run();
    end

    // main sequence
    initial begin
        rst_b = 1'b0;
        outputEnable_b = 1'b0;
        sleepRequest = 1'b0;
        burstOrderSel = 1'b1;
        t_powerup();
        t_burst(1'b1, 4'h5);
        t_burst(1'b0, 4'hA);
        t_modes(4'hA);
        t_sleep(4'h5);
        complete_run();
    end
endmodule

// *** rtl/burst_sequencer.sv ***
// low address bits of one burst step, linear or interleaved order
// assumes the caller holds the loaded start bits and the step count
`timescale 1ns/1ps

module burst_sequencer (
    input  wire logic [zbl_sram_pkg::BURST_W-1:0] startLow,
    input  wire logic [zbl_sram_pkg::BURST_W-1:0] step,
    input  wire logic                             interleaved,
    output logic      [zbl_sram_pkg::BURST_W-1:0] lowAddr
);

    // a 2-bit sum and xor both wrap to the start after four steps
    always_comb begin
        if (interleaved) begin
            lowAddr = startLow ^ step;                   // [RULE_18]
        end else begin
            lowAddr = startLow + step;                   // [RULE_18]
        end
    end

endmodule

// *** rtl/zbl_sram_pkg.sv ***
// shared constants, pin groups and states of the zero-latency sram port
// assumes one system clock; used by the port and its burst sequencer
package zbl_sram_pkg;

    localparam int LANE_W    = 8;   // data bits per byte lane
    localparam int WORD_W    = 18;  // two lanes plus two parity bits
    localparam int ADDR_W    = 18;  // word address width
    localparam int BURST_W   = 2;   // burst counter width
    localparam int SYNC_W    = 3;   // async pins brought in by synchroniser

    // synchroniser bit positions of the unclocked pins
    localparam int SYNC_OE_POS    = 2;  // output enable, active low
    localparam int SYNC_SLEEP_POS = 1;  // sleep request
    localparam int SYNC_MODE_POS  = 0;  // burst order select

    // reset values: outputs off, not asleep, interleaved order
    localparam logic [SYNC_W-1:0]  SYNC_RST  = 3'h5;
    localparam logic [BURST_W-1:0] COUNT_RST = 2'h0;
    localparam logic [BURST_W-1:0] COUNT_ONE = 2'h1;
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 18'h00000;
    localparam logic [1:0]         LANE_RST  = 2'h0;

    // one memory word as it sits on the data pins
    typedef struct packed {
        logic              parityLaneB;
        logic [LANE_W-1:0] dataLaneB;
        logic              parityLaneA;
        logic [LANE_W-1:0] dataLaneA;
    } word_s;

    localparam word_s WORD_RST = 18'h00000;

    // clocked address and control pins of one cycle
    typedef struct packed {
        logic              selectLowFirst_b;
        logic              selectLowSecond_b;
        logic              selectHigh;
        logic              advanceOrLoad;
        logic              readNotWrite;
        logic              laneAWriteStrobe_b;
        logic              laneBWriteStrobe_b;
        logic              clockEnable_b;
        logic [ADDR_W-1:0] address;
    } ctrl_s;

    // port state, gray along idle, read, write, sleep
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_READ  = 2'h1,
        ST_WRITE = 2'h3,
        ST_SLEEP = 2'h2
    } state_e;

    localparam state_e STATE_RST = ST_IDLE;

endpackage

// *** rtl/zbl_sram_port.sv ***
// zero bus latency flow-through sram port with its word array
// assumes controller logic on sys_clk drives the clocked pins; oe,
// sleep and burst order pins are asynchronous and synchronised here
//
// What this block does
// RULE_01 - selected only if both lows low, high high
// RULE_02 - each low lane strobe writes lane and parity
// RULE_03 - sleep ignores all inputs, stays in standby
// RULE_04 - controller enters sleep a cycle after writes
// RULE_05 - all clocked except oe, sleep, order select
// RULE_06 - drivers turn off by themselves during writes
// RULE_07 - data and parity float during power up
// RULE_08 - counter steps on every continue burst cycle
// RULE_09 - counter wraps to start after four cycles
// RULE_10 - burst direction fixed at begin burst cycle
// RULE_11 - no-op continue only after deselect, bus floats
// RULE_12 - dummy read floats, abort write stores nothing
// RULE_13 - disabled clock edge holds all, outputs unchanged; here oe and sleep still act on such an edge
// RULE_14 - open order pin reads high, open sleep low
// RULE_15 - deselect powers down, pending transfer completes
// RULE_16 - load low begins write or read by direction
// RULE_17 - advance ignores address and direction inputs
// RULE_18 - order select high interleaved, low linear
// RULE_19 - controller gives strobes a cycle before data
// RULE_20 - data follows address and control by one cycle
// RULE_21 - drive only on reads with output enable low
`timescale 1ns/1ps

module zbl_sram_port (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    input  wire zbl_sram_pkg::ctrl_s   ctrlIn,
    input  wire logic                  outputEnable_b,
    input  wire logic                  sleepRequest,
    input  wire logic                  burstOrderSel,
    input  wire zbl_sram_pkg::word_s   busIn,
    output zbl_sram_pkg::word_s        busOut_reg,
    output logic                       busOe_reg,
    output logic                       lowPower_reg
);

    localparam int DEPTH = 1 << zbl_sram_pkg::ADDR_W;

    // word array, no reset: contents are undefined at power up
    zbl_sram_pkg::word_s memArray [DEPTH];

    // synchroniser stages for the unclocked pins
    logic [zbl_sram_pkg::SYNC_W-1:0]  syncFirst_reg;   // first stage
    logic [zbl_sram_pkg::SYNC_W-1:0]  syncSecond_reg;  // stable copy
    logic [zbl_sram_pkg::SYNC_W-1:0]  pinLevel;        // resolved pins

    // sequencing state
    zbl_sram_pkg::state_e             state_reg;       // current op
    zbl_sram_pkg::state_e             state_next;
    logic [zbl_sram_pkg::ADDR_W-1:0]  base_reg;        // loaded address
    logic [zbl_sram_pkg::BURST_W-1:0] count_reg;       // burst step
    logic [zbl_sram_pkg::BURST_W-1:0] count_next;
    logic [zbl_sram_pkg::BURST_W-1:0] stepAhead;       // step to issue
    logic [zbl_sram_pkg::BURST_W-1:0] seqLow;          // stepped bits

    // write waiting for its data cycle
    logic                             wrPend_reg;
    logic [zbl_sram_pkg::ADDR_W-1:0]  wrAddr_reg;
    logic [1:0]                       wrLanes_reg;     // {b, a} enables

    // decode of the current edge
    logic                             oeSync_b;
    logic                             sleeping;
    logic                             interleaved;
    logic                             selected;
    logic                             edgeActive;
    logic                             loadCycle;
    logic                             burstGo;
    logic                             rdGo;
    logic                             wrGo;
    logic                             wrFire;
    logic                             readPhase_reg;   // data on bus
    logic                             readPhase_next;
    logic [zbl_sram_pkg::ADDR_W-1:0]  opAddr;          // issued address
    zbl_sram_pkg::word_s              rdWord;          // forwarded read

    // lane merge, used for array writes and for read forwarding
    function automatic zbl_sram_pkg::word_s mergeLanes(
        input zbl_sram_pkg::word_s oldWord,
        input zbl_sram_pkg::word_s newWord,
        input logic [1:0]          lanes
    );
        zbl_sram_pkg::word_s merged;
        merged = oldWord;
        if (lanes[0]) begin
            merged.dataLaneA   = newWord.dataLaneA;      // [RULE_02]
            merged.parityLaneA = newWord.parityLaneA;    // [RULE_02]
        end
        if (lanes[1]) begin
            merged.dataLaneB   = newWord.dataLaneB;      // [RULE_02]
            merged.parityLaneB = newWord.parityLaneB;    // [RULE_02]
        end
        return merged;
    endfunction

    // weak pulls: a floating order pin counts high, sleep counts low
    always_comb begin
        pinLevel = zbl_sram_pkg::SYNC_RST;
        pinLevel[zbl_sram_pkg::SYNC_OE_POS]    = outputEnable_b;
        pinLevel[zbl_sram_pkg::SYNC_SLEEP_POS] =
            (sleepRequest === 1'b1);                     // [RULE_14]
        pinLevel[zbl_sram_pkg::SYNC_MODE_POS]  =
            (burstOrderSel !== 1'b0);                    // [RULE_14]
    end

    // two-stage synchroniser; the pins have no clock relation
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncFirst_reg  <= zbl_sram_pkg::SYNC_RST;
            syncSecond_reg <= zbl_sram_pkg::SYNC_RST;
        end else begin
            syncFirst_reg  <= pinLevel;                  // [RULE_05]
            syncSecond_reg <= syncFirst_reg;
        end
    end

    assign oeSync_b    = syncSecond_reg[zbl_sram_pkg::SYNC_OE_POS];
    assign sleeping    = syncSecond_reg[zbl_sram_pkg::SYNC_SLEEP_POS];
    assign interleaved = syncSecond_reg[zbl_sram_pkg::SYNC_MODE_POS];

    // clocked pins are sampled directly at this edge
    assign selected   = ~ctrlIn.selectLowFirst_b &
                        ~ctrlIn.selectLowSecond_b &
                        ctrlIn.selectHigh;               // [RULE_01]
    assign edgeActive = ~ctrlIn.clockEnable_b;           // [RULE_13]
    assign loadCycle  = ~ctrlIn.advanceOrLoad;

    // continue only steps a live burst; after deselect it is a no-op
    assign burstGo = edgeActive & ~sleeping & ~loadCycle &
                     ((state_reg == zbl_sram_pkg::ST_READ) |
                      (state_reg == zbl_sram_pkg::ST_WRITE)); // [RULE_11]

    // next step of the counter, wrapping in two bits
    assign stepAhead = count_reg + zbl_sram_pkg::COUNT_ONE; // [RULE_09]

    burst_sequencer u_seq (
        .startLow    (base_reg[zbl_sram_pkg::BURST_W-1:0]),
        .step        (stepAhead),
        .interleaved (interleaved),
        .lowAddr     (seqLow)
    );

    // issued address: pins on load, stepped address on advance
    always_comb begin
        if (loadCycle) begin
            opAddr = ctrlIn.address;                     // [RULE_16]
        end else begin
            opAddr = {base_reg[zbl_sram_pkg::ADDR_W-1:
                               zbl_sram_pkg::BURST_W],
                      seqLow};                           // [RULE_17]
        end
    end

    // read or write issued at this edge; direction from the load
    always_comb begin
        rdGo = 1'b0;
        wrGo = 1'b0;
        if (edgeActive && !sleeping) begin               // [RULE_03]
            if (loadCycle) begin
                rdGo = selected & ctrlIn.readNotWrite;   // [RULE_16]
                wrGo = selected & ~ctrlIn.readNotWrite;  // [RULE_16]
            end else begin
                rdGo = (state_reg == zbl_sram_pkg::ST_READ);  // [RULE_10]
                wrGo = (state_reg == zbl_sram_pkg::ST_WRITE); // [RULE_10]
            end
        end
    end

    // the pending write completes at the next enabled edge
    assign wrFire = wrPend_reg & edgeActive;             // [RULE_20]

    // state decode; sleep wins over any load or continue
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        if (sleeping) begin
            state_next = zbl_sram_pkg::ST_SLEEP;         // [RULE_03]
        end else if (edgeActive) begin
            if (loadCycle) begin
                count_next = zbl_sram_pkg::COUNT_RST;
                if (!selected) begin
                    state_next = zbl_sram_pkg::ST_IDLE;  // [RULE_15]
                end else if (ctrlIn.readNotWrite) begin
                    state_next = zbl_sram_pkg::ST_READ;  // [RULE_16]
                end else begin
                    state_next = zbl_sram_pkg::ST_WRITE; // [RULE_16]
                end
            end else if (burstGo) begin
                count_next = stepAhead;                  // [RULE_08]
            end else begin
                // continue with no burst: leave sleep as deselect
                state_next = zbl_sram_pkg::ST_IDLE;      // [RULE_11]
            end
        end
    end

    // state, burst base and counter; a disabled edge holds base and counter, and the state unless asleep
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= zbl_sram_pkg::STATE_RST;
            count_reg <= zbl_sram_pkg::COUNT_RST;
            base_reg  <= zbl_sram_pkg::ADDR_RST;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;                     // [RULE_08]
            if (edgeActive && !sleeping && loadCycle && selected) begin
                base_reg <= ctrlIn.address;              // [RULE_09]
            end
        end
    end

    // write address and lanes held for the data cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_reg  <= 1'b0;
            wrAddr_reg  <= zbl_sram_pkg::ADDR_RST;
            wrLanes_reg <= zbl_sram_pkg::LANE_RST;
        end else if (edgeActive) begin
            wrPend_reg  <= wrGo;                         // [RULE_20]
            wrAddr_reg  <= opAddr;
            // strobes travel with address, data comes one cycle later
            wrLanes_reg <= {~ctrlIn.laneBWriteStrobe_b,
                            ~ctrlIn.laneAWriteStrobe_b}; // [RULE_19]
        end
    end

    // array write; both strobes high leaves the word unchanged
    always_ff @(posedge sys_clk) begin
        if (wrFire) begin
            memArray[wrAddr_reg] <= mergeLanes(memArray[wrAddr_reg],
                                               busIn,
                                               wrLanes_reg); // [RULE_12]
        end
    end

    // read forwarding: a write landing this edge on the same word
    // would otherwise be missed by the array read
    always_comb begin
        rdWord = memArray[opAddr];
        if (wrFire && (wrAddr_reg == opAddr)) begin
            rdWord = mergeLanes(rdWord, busIn, wrLanes_reg); // [RULE_20]
        end
    end

    // read data register; held through disabled edges
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            busOut_reg <= zbl_sram_pkg::WORD_RST;
        end else if (rdGo) begin
            busOut_reg <= rdWord;                        // [RULE_20]
        end
    end

    // bus phase: read data owns the bus the cycle after issue
    always_comb begin
        readPhase_next = readPhase_reg;                  // [RULE_13]
        if (sleeping) begin
            readPhase_next = 1'b0;                       // [RULE_03]
        end else if (edgeActive) begin
            // writes, deselects and no-ops release the bus
            readPhase_next = rdGo;                       // [RULE_06]
        end
    end

    // driver enable; oe still acts on a disabled edge, but late by
    // the synchroniser, which costs two cycles of oe response
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            readPhase_reg <= 1'b0;
            busOe_reg     <= 1'b0;                       // [RULE_07]
        end else begin
            readPhase_reg <= readPhase_next;             // [RULE_15]
            busOe_reg     <= readPhase_next & ~oeSync_b; // [RULE_21]
        end
    end

    // standby flag: deselected or asleep
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lowPower_reg <= 1'b1;
        end else begin
            lowPower_reg <= (state_next == zbl_sram_pkg::ST_IDLE) |
                            (state_next == zbl_sram_pkg::ST_SLEEP); // [RULE_15]
        end
    end

endmodule
